// ---- pkg/cpu_exec_consts.svh ----
`ifndef CPU_EXEC_CONSTS_SVH
`define CPU_EXEC_CONSTS_SVH

// Register byte addresses
`define OFS_INSTR     12'h000
`define OFS_STATUS    12'h004
`define OFS_FLAGS     12'h008
`define OFS_MEM_ADDR  12'h00C
`define OFS_MEM_DATA  12'h010
// Pointer registers by index, byte address is four times the index
`define IDX_WWB_ZERO  12'h0D6
`define IDX_WWB_ONE   12'h0D7
`define OFS_WWB_ZERO  (`IDX_WWB_ZERO << 2)
`define OFS_WWB_ONE   (`IDX_WWB_ONE << 2)

// Flag register bit positions
`define FLAG_C  7
`define FLAG_Z  6
`define FLAG_S  5
`define FLAG_V  4
`define FLAG_D  3
`define FLAG_H  2
`define FLAG_B  0

// Reset values
`define RST_FLAGS  8'h00
`define RST_WWB    8'h00

// Opcodes
`define OPC_RRC_R   8'hC0
`define OPC_RRC_IR  8'hC1
`define OPC_SB0     8'h4F
`define OPC_SB1     8'h5F
`define OPC_SCF     8'hDF
`define OPC_SRA_R   8'hD0
`define OPC_SRA_IR  8'hD1
`define OPC_PTR     8'h31
`define OPC_STOP    8'h7F
`define OPC_SWAP_R  8'hF0
`define OPC_SUB_HI  4'h2
`define OPC_SBC_HI  4'h3

// Execution times in CPU cycles
`define CYC_SHORT  3'h4
`define CYC_LONG   3'h6

// AXI answers
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ---- pkg/cpu_exec_pkg.sv ----
package cpu_exec_pkg;

	typedef logic [1:0] resp_type;

	typedef enum logic [3:0] {
		OP_SUB,
		OP_SBC,
		OP_SRA,
		OP_RRC,
		OP_SWAP,
		OP_PTR,
		OP_SB0,
		OP_SB1,
		OP_SCF,
		OP_STOP,
		OP_BAD
	} op_class_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_OPER,
		ST_WAIT
	} state_type;

endpackage

// ---- rtl/exec_byte_mem.sv ----
`timescale 1ns/100ps
// Register file bytes, two registered read ports, one write port
module exec_byte_mem (
	input  wire logic       clk_sys_in,
	input  wire logic       nrst_in,
	input  wire logic [7:0] ra_in,
	input  wire logic [7:0] rb_in,
	input  wire logic       we_in,
	input  wire logic [7:0] wa_in,
	input  wire logic [7:0] wd_in,
	output logic      [7:0] rda_out,
	output logic      [7:0] rdb_out
);
	logic [7:0] mem_q [0:255];

	always_ff @(posedge clk_sys_in) begin
		if (we_in) begin
			mem_q[wa_in] <= wd_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			rda_out <= 8'h00;
			rdb_out <= 8'h00;
		end else begin
			rda_out <= mem_q[ra_in];
			rdb_out <= mem_q[rb_in];
		end
	end
endmodule

// ---- rtl/cpu_exec_subtract_shift_bank_ops.sv ----
`timescale 1ns/100ps
`include "cpu_exec_consts.svh"
// Operation
// - Rotate right through carry, opcodes C0, C1
// - Opcode 4F clears bank flag only
// - Opcode 5F sets bank flag only
// - Subtract with borrow, opcodes 32 to 36
// - Borrow-subtract flags: C,Z,S,V,D=1,H
// - Opcodes 22, 32 take 4 cycles, other subtract forms 6
// - Plain subtract, opcodes 22 to 26
// - Plain subtract flags: C,Z,S,V,D=1,H
// - Opcode DF forces carry only
// - Arithmetic shift right, opcodes D0, D1
// - Shift flags: C=bit0, V=0, D,H kept
// - Pointer load decodes source bits 1:0
// - Pointers at D6/D7, flags unchanged
// - Opcode 7F enters stop state
// - Stop keeps state; interrupt or reset releases
// - Opcode F0 swaps nibbles
// - Swap flags: Z,S from result, D,H kept
module cpu_exec_subtract_shift_bank_ops (
	input  wire logic                     clk_sys_in,
	input  wire logic                     nrst_in,
	input  wire logic                     ext_int_in,
	input  wire logic [11:0]              awaddr_in,
	input  wire logic                     awvalid_in,
	output logic                          awready_out,
	input  wire logic [31:0]              wdata_in,
	input  wire logic [3:0]               wstrb_in,
	input  wire logic                     wvalid_in,
	output logic                          wready_out,
	output cpu_exec_pkg::resp_type        bresp_out,
	output logic                          bvalid_out,
	input  wire logic                     bready_in,
	input  wire logic [11:0]              araddr_in,
	input  wire logic                     arvalid_in,
	output logic                          arready_out,
	output logic [31:0]                   rdata_out,
	output cpu_exec_pkg::resp_type        rresp_out,
	output logic                          rvalid_out,
	input  wire logic                     rready_in,
	output logic                          stop_mode_out
);
	import cpu_exec_pkg::*;

	state_type    state_q;
	op_class_type cls;
	logic [7:0]   op_q, dst_q, src_q, ra_q, rb_q, mem_addr_q, result_q;
	logic [7:0]   flags_q, wwb_zero_q, wwb_one_q, rda, rdb;
	logic [2:0]   cnt_q;
	logic         ind_done_q, stopped_q, bad_op_q, int_meta_q, int_sync_q;
	logic         aw_held_q, w_held_q;
	logic [11:0]  aw_addr_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	logic         wr_fire, wr_ok, wr_instr, wr_flags, wr_ptr0, wr_ptr1, wr_maddr, wr_mdata;
	logic         need_ind, dst_ind, src_imm, exec_fire, mem_we;
	logic [7:0]   d, s, res_d, flags_d, wwb_zero_d, wwb_one_d, mem_wa, mem_wd;
	logic [8:0]   dif9;
	logic [4:0]   lo5;
	logic         cin, res_wr_d;
	logic [31:0]  rd_val;
	resp_type     rd_resp;

	function automatic op_class_type op_class(input logic [7:0] op);
		if (op[7:4] == `OPC_SUB_HI && op[3:0] >= 4'h2 && op[3:0] <= 4'h6) begin
			return OP_SUB;
		end
		if (op[7:4] == `OPC_SBC_HI && op[3:0] >= 4'h2 && op[3:0] <= 4'h6) begin
			return OP_SBC;
		end
		case (op)
			`OPC_SRA_R, `OPC_SRA_IR: return OP_SRA;
			`OPC_RRC_R, `OPC_RRC_IR: return OP_RRC;
			`OPC_SWAP_R:             return OP_SWAP;
			`OPC_PTR:                return OP_PTR;
			`OPC_SB0:                return OP_SB0;
			`OPC_SB1:                return OP_SB1;
			`OPC_SCF:                return OP_SCF;
			`OPC_STOP:               return OP_STOP;
			default:                 return OP_BAD;
		endcase
	endfunction

	function automatic logic [2:0] op_cycles(input logic [7:0] op);
		op_class_type c;
		c = op_class(op);
		if ((c == OP_SUB || c == OP_SBC) && op[3:0] != 4'h2) begin
			return `CYC_LONG;
		end
		return `CYC_SHORT;
	endfunction

	// Byte registers live in lane 0 only
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] nw, input logic [3:0] st);
		return st[0] ? nw[7:0] : old;
	endfunction

	// Working register: upper five bits from the selected pointer
	function automatic logic [7:0] wr_addr(input logic [7:0] r, input logic [7:0] p0, input logic [7:0] p1);
		return {(r[3] ? p1[7:3] : p0[7:3]), r[2:0]};
	endfunction

	assign cls       = op_class(op_q);
	assign src_imm   = (cls == OP_PTR) || ((cls == OP_SUB || cls == OP_SBC) && op_q[3:0] == 4'h6);
	assign dst_ind   = (op_q == `OPC_SRA_IR) || (op_q == `OPC_RRC_IR);
	assign need_ind  = dst_ind || ((cls == OP_SUB || cls == OP_SBC) && (op_q[3:0] == 4'h3 || op_q[3:0] == 4'h5));
	assign exec_fire = (state_q == ST_OPER) && (!need_ind || ind_done_q);

	exec_byte_mem u_mem (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.ra_in      (ra_q),
		.rb_in      (rb_q),
		.we_in      (mem_we),
		.wa_in      (mem_wa),
		.wd_in      (mem_wd),
		.rda_out    (rda),
		.rdb_out    (rdb)
	);

	// Execution
	always_comb begin
		d          = rda;
		s          = src_imm ? src_q : rdb;
		cin        = (cls == OP_SBC) ? flags_q[`FLAG_C] : 1'b0;
		dif9       = {1'b0, d} - {1'b0, s} - {8'h00, cin};
		lo5        = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, cin};
		res_d      = d;
		res_wr_d   = 1'b0;
		flags_d    = flags_q;
		wwb_zero_d = wwb_zero_q;
		wwb_one_d  = wwb_one_q;
		case (cls)
			OP_SUB, OP_SBC: begin
				res_d            = dif9[7:0];
				res_wr_d         = 1'b1;
				flags_d[`FLAG_C] = dif9[8];
				flags_d[`FLAG_V] = (d[7] ^ s[7]) & ~(dif9[7] ^ s[7]);
				flags_d[`FLAG_D] = 1'b1;
				flags_d[`FLAG_H] = lo5[4];
			end
			OP_SRA: begin
				res_d            = {d[7], d[7:1]};
				res_wr_d         = 1'b1;
				flags_d[`FLAG_C] = d[0];
				flags_d[`FLAG_V] = 1'b0;
			end
			OP_RRC: begin
				res_d            = {flags_q[`FLAG_C], d[7:1]};
				res_wr_d         = 1'b1;
				flags_d[`FLAG_C] = d[0];
				flags_d[`FLAG_V] = d[7] ^ flags_q[`FLAG_C];
			end
			OP_SWAP: begin
				res_d    = {d[3:0], d[7:4]};
				res_wr_d = 1'b1;
			end
			OP_PTR: begin
				case (src_q[1:0])
					2'b10: wwb_zero_d[7:3] = src_q[7:3];
					2'b01: wwb_one_d[7:3]  = src_q[7:3];
					2'b00: begin
						wwb_zero_d = {src_q[7:4], 4'h0};
						wwb_one_d  = {src_q[7:4], 4'h8};
					end
					default: ;
				endcase
			end
			OP_SB0:  flags_d[`FLAG_B] = 1'b0;
			OP_SB1:  flags_d[`FLAG_B] = 1'b1;
			OP_SCF:  flags_d[`FLAG_C] = 1'b1;
			default: ;
		endcase
		if (res_wr_d) begin
			flags_d[`FLAG_Z] = (res_d == 8'h00);
			flags_d[`FLAG_S] = res_d[7];
		end
	end

	assign mem_we = (exec_fire && res_wr_d) || wr_mdata;
	assign mem_wa = exec_fire ? ra_q : mem_addr_q;
	assign mem_wd = exec_fire ? res_d : wdata_q[7:0];

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			state_q    <= ST_IDLE;
			op_q       <= 8'h00;
			dst_q      <= 8'h00;
			src_q      <= 8'h00;
			ra_q       <= 8'h00;
			rb_q       <= 8'h00;
			cnt_q      <= 3'h0;
			ind_done_q <= 1'b0;
		end else begin
			if (state_q != ST_IDLE) begin
				cnt_q <= cnt_q - 3'h1;
			end
			case (state_q)
				ST_IDLE: begin
					ra_q <= mem_addr_q;
					if (wr_instr) begin
						op_q       <= wdata_q[7:0];
						dst_q      <= wdata_q[15:8];
						src_q      <= wdata_q[23:16];
						cnt_q      <= op_cycles(wdata_q[7:0]);
						ind_done_q <= 1'b0;
						state_q    <= ST_LOAD;
						if (wdata_q[7:4] == `OPC_SUB_HI || wdata_q[7:4] == `OPC_SBC_HI) begin
							if (wdata_q[3:0] <= 4'h3) begin
								ra_q <= wr_addr(wdata_q[15:8], wwb_zero_q, wwb_one_q);
								rb_q <= wr_addr(wdata_q[23:16], wwb_zero_q, wwb_one_q);
							end else begin
								ra_q <= wdata_q[15:8];
								rb_q <= wdata_q[23:16];
							end
						end else begin
							ra_q <= wdata_q[15:8];
							rb_q <= wdata_q[23:16];
						end
					end
				end
				ST_LOAD: state_q <= ST_OPER;
				ST_OPER: begin
					if (!exec_fire) begin
						ind_done_q <= 1'b1;
						state_q    <= ST_LOAD;
						if (dst_ind) begin
							ra_q <= rda;
						end else begin
							rb_q <= rdb;
						end
					end else begin
						state_q <= (cnt_q <= 3'h1) ? ST_IDLE : ST_WAIT;
					end
				end
				ST_WAIT: state_q <= (cnt_q <= 3'h1) ? ST_IDLE : ST_WAIT;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			flags_q    <= `RST_FLAGS;
			wwb_zero_q <= `RST_WWB;
			wwb_one_q  <= `RST_WWB;
			result_q   <= 8'h00;
			bad_op_q   <= 1'b0;
		end else if (exec_fire) begin
			flags_q    <= flags_d;
			wwb_zero_q <= wwb_zero_d;
			wwb_one_q  <= wwb_one_d;
			result_q   <= res_d;
			bad_op_q   <= (cls == OP_BAD);
		end else begin
			if (wr_flags) begin
				flags_q <= merge(flags_q, wdata_q, wstrb_q);
			end
			if (wr_ptr0) begin
				wwb_zero_q <= merge(wwb_zero_q, wdata_q, wstrb_q);
			end
			if (wr_ptr1) begin
				wwb_one_q <= merge(wwb_one_q, wdata_q, wstrb_q);
			end
		end
	end

	// Stop state and its release by the external interrupt pin
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			int_meta_q    <= 1'b0;
			int_sync_q    <= 1'b0;
			stopped_q     <= 1'b0;
			stop_mode_out <= 1'b0;
		end else begin
			int_meta_q <= ext_int_in;
			int_sync_q <= int_meta_q;
			if (exec_fire && cls == OP_STOP) begin
				stopped_q     <= 1'b1;
				stop_mode_out <= 1'b1;
			end else if (int_sync_q) begin
				stopped_q     <= 1'b0;
				stop_mode_out <= 1'b0;
			end
		end
	end

	// Register bus
	assign wr_fire  = aw_held_q && w_held_q && !bvalid_out;
	assign wr_ok    = wr_fire && state_q == ST_IDLE && !stopped_q;
	assign wr_instr = wr_ok && aw_addr_q == `OFS_INSTR;
	assign wr_flags = wr_ok && aw_addr_q == `OFS_FLAGS;
	assign wr_maddr = wr_ok && aw_addr_q == `OFS_MEM_ADDR;
	assign wr_mdata = wr_ok && aw_addr_q == `OFS_MEM_DATA && wstrb_q[0];
	assign wr_ptr0  = wr_ok && aw_addr_q == `OFS_WWB_ZERO;
	assign wr_ptr1  = wr_ok && aw_addr_q == `OFS_WWB_ONE;

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			aw_held_q   <= 1'b0;
			w_held_q    <= 1'b0;
			awready_out <= 1'b1;
			wready_out  <= 1'b1;
			bvalid_out  <= 1'b0;
			bresp_out   <= `RESP_OKAY;
			aw_addr_q   <= 12'h000;
			wdata_q     <= 32'h0000_0000;
			wstrb_q     <= 4'h0;
			mem_addr_q  <= 8'h00;
		end else begin
			if (awvalid_in && awready_out) begin
				aw_held_q   <= 1'b1;
				awready_out <= 1'b0;
				aw_addr_q   <= {awaddr_in[11:2], 2'b00};
			end
			if (wvalid_in && wready_out) begin
				w_held_q   <= 1'b1;
				wready_out <= 1'b0;
				wdata_q    <= wdata_in;
				wstrb_q    <= wstrb_in;
			end
			if (wr_fire) begin
				aw_held_q  <= 1'b0;
				w_held_q   <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out  <= (wr_instr || wr_flags || wr_maddr || wr_ptr0 || wr_ptr1
					|| (wr_ok && aw_addr_q == `OFS_MEM_DATA)) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (wr_maddr && wstrb_q[0]) begin
				mem_addr_q <= wdata_q[7:0];
			end
			if (bvalid_out && bready_in) begin
				bvalid_out  <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_val  = 32'h0000_0000;
		rd_resp = `RESP_OKAY;
		case ({araddr_in[11:2], 2'b00})
			`OFS_INSTR:                    rd_val = {8'h00, src_q, dst_q, op_q};
			`OFS_STATUS:                   rd_val = {8'h00, result_q, flags_q, 5'h00, bad_op_q, stopped_q,
				state_q != ST_IDLE};
			`OFS_FLAGS:                    rd_val = {24'h0, flags_q};
			`OFS_MEM_ADDR:                 rd_val = {24'h0, mem_addr_q};
			`OFS_MEM_DATA:                 rd_val = {24'h0, rda};
			`OFS_WWB_ZERO:                 rd_val = {24'h0, wwb_zero_q};
			`OFS_WWB_ONE:                  rd_val = {24'h0, wwb_one_q};
			default:                       rd_resp = `RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			arready_out <= 1'b1;
			rvalid_out  <= 1'b0;
			rdata_out   <= 32'h0000_0000;
			rresp_out   <= `RESP_OKAY;
		end else if (arvalid_in && arready_out) begin
			arready_out <= 1'b0;
			rvalid_out  <= 1'b1;
			rdata_out   <= rd_val;
			rresp_out   <= rd_resp;
		end else if (rvalid_out && rready_in) begin
			rvalid_out  <= 1'b0;
			arready_out <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	sequence s_fire(op_class_type c);
		exec_fire && cls == c;
	endsequence

	sequence s_short_launch;
		state_q == ST_IDLE ##1 state_q == ST_LOAD && op_cycles(op_q) == `CYC_SHORT;
	endsequence

	a_bank_zero_clear: assert property (s_fire(OP_SB0) |=> !flags_q[`FLAG_B]
		&& flags_q[7:1] == $past(flags_q[7:1])) else $error("bank zero select wrong");
	a_bank_one_set: assert property (s_fire(OP_SB1) |=> flags_q[`FLAG_B]
		&& flags_q[7:1] == $past(flags_q[7:1])) else $error("bank one select wrong");
	a_carry_force: assert property (s_fire(OP_SCF) |=> flags_q[`FLAG_C]
		&& flags_q[6:0] == $past(flags_q[6:0])) else $error("carry force wrong");
	a_sub_decimal_flag: assert property ((s_fire(OP_SUB) or s_fire(OP_SBC)) |=> flags_q[`FLAG_D]
		&& flags_q[`FLAG_C] == $past(dif9[8])) else $error("subtract flags wrong");
	a_shift_clears_v: assert property (s_fire(OP_SRA) |=> !flags_q[`FLAG_V]
		&& flags_q[`FLAG_C] == $past(rda[0])) else $error("shift flags wrong");
	a_short_busy_len: assert property (s_short_launch |->
		(state_q != ST_IDLE)[*4] ##1 state_q == ST_IDLE) else $error("short op length wrong");
	a_ptr_keeps_flags: assert property (s_fire(OP_PTR) |=> $stable(flags_q))
		else $error("pointer load changed flags");
	a_ptr_odd_keep: assert property (s_fire(OP_PTR) ##0 src_q[1:0] == 2'b11 |=>
		$stable(wwb_zero_q) && $stable(wwb_one_q)) else $error("pointer pattern 11 changed pointers");
	a_stop_enter: assert property (s_fire(OP_STOP) |=> stopped_q && stop_mode_out)
		else $error("stop not entered");
	a_stop_retain: assert property (stopped_q && !int_sync_q |=> stopped_q
		&& $stable(flags_q) && $stable(wwb_zero_q) && $stable(wwb_one_q)) else $error("stop state lost");
endmodule

// ---- bench/cpu_exec_subtract_shift_bank_ops_tb.sv ----
`timescale 1ns/100ps
`include "cpu_exec_consts.svh"
module cpu_exec_subtract_shift_bank_ops_tb;
	import cpu_exec_pkg::*;

	localparam logic [11:0] PTR0 = 12'(`IDX_WWB_ZERO << 2);
	localparam logic [11:0] PTR1 = 12'(`IDX_WWB_ONE << 2);

	logic        clk_sys_in;
	logic        nrst_in;
	logic        ext_int_in;
	logic [11:0] awaddr_in;
	logic [11:0] araddr_in;
	logic [31:0] wdata_in;
	logic [31:0] rdata_out;
	logic [3:0]  wstrb_in;
	logic        awvalid_in;
	logic        awready_out;
	logic        wvalid_in;
	logic        wready_out;
	logic        bvalid_out;
	logic        bready_in;
	logic        arvalid_in;
	logic        arready_out;
	logic        rvalid_out;
	logic        rready_in;
	logic        stop_mode_out;
	resp_type    bresp_out;
	resp_type    rresp_out;
	resp_type    rp;
	logic [31:0] rd;
	logic [7:0]  fl;
	logic [7:0]  rs;
	logic [7:0]  op;
	logic [7:0]  dst;
	logic [7:0]  src;
	logic [7:0]  dv;
	logic [7:0]  sv;
	logic [7:0]  fi;
	logic [7:0]  er;
	logic [7:0]  ef;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;

	// Opcode, dst, src, dst value, src value, flags in, result, flags out
	logic [63:0] rows [17] = '{
		64'h24_01_02_21_03_00_1E_0C, 64'h26_01_90_21_00_00_91_B8, 64'h26_01_65_21_00_00_BC_AC,
		64'h24_01_02_55_55_01_00_49, 64'h34_01_02_20_03_80_1C_0C, 64'h36_01_8A_20_00_80_95_BC,
		64'h34_01_02_07_07_00_00_48, 64'hD0_01_00_9A_00_9C_CD_2C, 64'hD0_01_00_01_00_00_00_C0,
		64'hC0_01_00_55_00_0C_2A_8C, 64'hC0_01_00_02_00_80_81_30, 64'hF0_01_00_3E_00_9C_E3_BC,
		64'hF0_01_00_00_00_20_00_40, 64'hDF_01_00_33_00_7D_33_FD, 64'h4F_01_00_44_00_FF_44_FE,
		64'h5F_01_00_44_00_00_44_01, 64'h01_01_00_44_00_5A_44_5A};
	// Pointer source, expected pointer zero, expected pointer one
	logic [23:0] ptab [4] = '{24'h40_40_48, 24'h52_50_48, 24'h6D_50_68, 24'hFF_50_68};

	cpu_exec_subtract_shift_bank_ops dut (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ext_int_in(ext_int_in),
		.awaddr_in(awaddr_in), .awvalid_in(awvalid_in), .awready_out(awready_out),
		.wdata_in(wdata_in), .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
		.bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
		.araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
		.rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
		.rready_in(rready_in), .stop_mode_out(stop_mode_out));

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_resp(input resp_type g, input resp_type e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output resp_type r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk_sys_in);
		awaddr_in  <= a;
		wdata_in   <= d;
		awvalid_in <= 1'b1;
		wvalid_in  <= 1'b1;
		bready_in  <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (!ad && awready_out === 1'b1) begin
				ad = 1'b1;
				awvalid_in <= 1'b0;
			end
			if (!wd && wready_out === 1'b1) begin
				wd = 1'b1;
				wvalid_in <= 1'b0;
			end
		end while (bvalid_out !== 1'b1);
		r = bresp_out;
		bready_in <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output resp_type r);
		@(posedge clk_sys_in);
		araddr_in  <= a;
		arvalid_in <= 1'b1;
		rready_in  <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (arready_out === 1'b1) begin
				arvalid_in <= 1'b0;
			end
		end while (rvalid_out !== 1'b1);
		d = rdata_out;
		r = rresp_out;
		rready_in <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		axi_wr(a, {24'h000000, d}, rp);
		chk_resp(rp, `RESP_OKAY);
	endtask

	task automatic rd8(input logic [11:0] a, output logic [7:0] v);
		axi_rd(a, rd, rp);
		chk_resp(rp, `RESP_OKAY);
		v = rd[7:0];
	endtask

	task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
		wr(`OFS_MEM_ADDR, a);
		wr(`OFS_MEM_DATA, d);
	endtask

	task automatic mem_rd(input logic [7:0] a, output logic [7:0] v);
		wr(`OFS_MEM_ADDR, a);
		repeat (2) @(posedge clk_sys_in);
		rd8(`OFS_MEM_DATA, v);
	endtask

	task automatic wait_idle();
		do begin
			axi_rd(`OFS_STATUS, rd, rp);
		end while (rd[0] !== 1'b0);
	endtask

	task automatic run(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s);
		axi_wr(`OFS_INSTR, {8'h00, s, d, o}, rp);
		chk_resp(rp, `RESP_OKAY);
		wait_idle();
	endtask

	initial begin
		nrst_in = 1'b0;
		ext_int_in = 1'b0;
		awaddr_in = 12'h000;
		araddr_in = 12'h000;
		wdata_in = 32'h00000000;
		wstrb_in = 4'hF;
		awvalid_in = 1'b0;
		wvalid_in = 1'b0;
		bready_in = 1'b0;
		arvalid_in = 1'b0;
		rready_in = 1'b0;
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, `RST_FLAGS);
		rd8(PTR0, fl);
		chk_byte(fl, `RST_WWB);
		rd8(PTR1, fl);
		chk_byte(fl, `RST_WWB);
		axi_rd(12'h100, rd, rp);
		chk_resp(rp, `RESP_SLVERR);
		chk_byte(rd[7:0], 8'h00);
		axi_wr(`OFS_STATUS, 32'h00000000, rp);
		chk_resp(rp, `RESP_SLVERR);
		foreach (rows[i]) begin
			{op, dst, src, dv, sv, fi, er, ef} = rows[i];
			mem_wr(src, sv);
			mem_wr(dst, dv);
			wr(`OFS_FLAGS, fi);
			run(op, dst, src);
			mem_rd(dst, rs);
			chk_byte(rs, er);
			rd8(`OFS_FLAGS, fl);
			chk_byte(fl, ef);
			mem_rd(src, rs);
			chk_byte(rs, sv);
		end
		// Indirect shift: address held in register 02
		mem_wr(8'h03, 8'hBC);
		mem_wr(8'h02, 8'h03);
		wr(`OFS_FLAGS, 8'h01);
		run(8'hD1, 8'h02, 8'h00);
		mem_rd(8'h03, rs);
		chk_byte(rs, 8'hDE);
		mem_rd(8'h02, rs);
		chk_byte(rs, 8'h03);
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'h21);
		// Indirect rotate: address held in register 01
		mem_wr(8'h01, 8'h02);
		mem_wr(8'h02, 8'h17);
		wr(`OFS_FLAGS, 8'h00);
		run(8'hC1, 8'h01, 8'h00);
		mem_rd(8'h02, rs);
		chk_byte(rs, 8'h0B);
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'h80);
		// Indirect source subtract: address held in register 02
		mem_wr(8'h01, 8'h21);
		mem_wr(8'h02, 8'h03);
		mem_wr(8'h03, 8'h0A);
		run(8'h25, 8'h01, 8'h02);
		mem_rd(8'h01, rs);
		chk_byte(rs, 8'h17);
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'h0C);
		wr(`OFS_FLAGS, 8'hA5);
		foreach (ptab[i]) begin
			run(8'h31, 8'h00, ptab[i][23:16]);
			rd8(PTR0, fl);
			chk_byte(fl, ptab[i][15:8]);
			rd8(PTR1, fl);
			chk_byte(fl, ptab[i][7:0]);
		end
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'hA5);
		// Working registers through pointers 50 and 68
		mem_wr(8'h69, 8'h12);
		mem_wr(8'h52, 8'h03);
		wr(`OFS_FLAGS, 8'h00);
		run(8'h22, 8'h09, 8'h02);
		mem_rd(8'h69, rs);
		chk_byte(rs, 8'h0F);
		mem_rd(8'h52, rs);
		chk_byte(rs, 8'h03);
		// Working destination, indirect working source pointing at register 03
		mem_wr(8'h51, 8'h12);
		mem_wr(8'h03, 8'h0A);
		run(8'h23, 8'h01, 8'h02);
		mem_rd(8'h51, rs);
		chk_byte(rs, 8'h08);
		// Write during a six-cycle operation is refused
		mem_wr(8'h01, 8'h21);
		mem_wr(8'h02, 8'h03);
		wr(`OFS_FLAGS, 8'h00);
		axi_wr(`OFS_INSTR, 32'h00020124, rp);
		chk_resp(rp, `RESP_OKAY);
		axi_wr(`OFS_FLAGS, 32'h000000FF, rp);
		chk_resp(rp, `RESP_SLVERR);
		wait_idle();
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'h0C);
		wr(`OFS_FLAGS, 8'h5A);
		run(8'h7F, 8'h00, 8'h00);
		chk_bit(stop_mode_out, 1'b1);
		axi_wr(`OFS_FLAGS, 32'h00000000, rp);
		chk_resp(rp, `RESP_SLVERR);
		axi_rd(`OFS_STATUS, rd, rp);
		chk_bit(rd[1], 1'b1);
		rd8(`OFS_FLAGS, fl);
		chk_byte(fl, 8'h5A);
		rd8(PTR1, fl);
		chk_byte(fl, 8'h68);
		ext_int_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		chk_bit(stop_mode_out, 1'b0);
		ext_int_in <= 1'b0;
		wr(`OFS_FLAGS, 8'h00);
		// Stop again, then leave it through reset
		run(8'h7F, 8'h00, 8'h00);
		chk_bit(stop_mode_out, 1'b1);
		nrst_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		chk_bit(stop_mode_out, 1'b0);
		rd8(PTR0, fl);
		chk_byte(fl, `RST_WWB);
		give_verdict();
	end
endmodule
